// ===== rtl/reset_register_initializer.sv
// Reset-value loader for the special register file, reached over APB
// Function
// - Interrupt wake with global enable set loads program counter low with vector 04h.
// - Brown-out reset with supply not low clears bit 0 of power control.
// - Any other reset keeps bit 0 of power control.
// - Wake-up leaves at least one interrupt flag set marking its source.
// - Port pins selected analog read back as zero.
// - Unimplemented bits always read zero.
// - Other reset with supply too low is handled as power-on.
// - Power-on bit of power control is zero after power-on, kept otherwise.
// - Every reset except a wake-up clears the global interrupt enable; a wake keeps it.
`timescale 1ns/1ps
module reset_register_initializer
  import reset_init_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire reset_req_t rst_req,
  input wire logic [5:0] port_a_analog,
  input wire logic [5:0] port_c_analog,
  output logic irq,
  output logic load_done,
  output logic global_irq_enable,
  output logic [7:0] program_counter_low
);
  byte_t regs_r [NREG];
  byte_t base_nxt [NREG];
  byte_t reg_nxt [NREG];
  byte_t wmask [NREG];
  logic [NREG-1:0] hit;
  logic [NEV-1:0] stat_r;
  logic [NEV-1:0] stat_nxt;
  logic [NEV-1:0] stat_seen_r;
  logic [NEV-1:0] mask_r;
  logic [NEV-1:0] mask_nxt;
  logic [NEV-1:0] ev_set;
  logic hit_stat;
  logic hit_mask;
  logic mapped;
  logic acc;
  logic done;
  logic wr_en;
  logic rd_done;
  logic load;
  reset_class_t cls;
  byte_t rd_data;
  logic [7:0] wake_flags;

  assign acc = psel && penable;
  assign done = acc && pready;
  assign hit_stat = (paddr[AW-1:2] == {2'b00, EV_STAT_IDX});
  assign hit_mask = (paddr[AW-1:2] == {2'b00, EV_MASK_IDX});
  assign mapped = (|hit) || hit_stat || hit_mask;
  // A reset load in the same cycle takes priority over a bus write
  assign load = rst_req.valid;
  assign wr_en = done && pwrite && !load;
  assign rd_done = done && !pwrite;

  // Reset class; a supply dip turns any non-wake reset into power-on
  always_comb begin
    case (rst_req.kind)
      RK_POR: cls = CL_POR;
      RK_WAKE_IRQ, RK_WAKE_WATCHDOG: cls = CL_WAKE;
      default: cls = rst_req.supply_low ? CL_POR : CL_OTHER;
    endcase
  end

  genvar i;
  generate
    for (i = 0; i < NREG; i++) begin : g_reg
      assign hit[i] = (paddr[AW-1:2] == {2'b00, REG_OFF[i]});
      if (i == SLOT_CONV_RES) begin : g_ro
        assign wmask[i] = 8'h00;
      end else if (i == SLOT_CORE_FLAGS) begin : g_cf
        assign wmask[i] = CORE_FLAGS_WR;
      end else begin : g_rw
        assign wmask[i] = REG_IMPL[i];
      end
      always_comb begin
        base_nxt[i] = regs_r[i];
        if (load) begin
          if (cls == CL_POR) begin
            base_nxt[i] = (regs_r[i] & ~REG_POR_DEF[i]) | REG_POR_VAL[i];
          end else if (cls == CL_OTHER) begin
            base_nxt[i] = (regs_r[i] & ~REG_OTH_DEF[i]) | REG_OTH_VAL[i];
          end
        end else if (wr_en && hit[i]) begin
          base_nxt[i] = (regs_r[i] & ~wmask[i]) | (pwdata[7:0] & wmask[i]);
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_r[i] <= REG_POR_VAL[i] & REG_IMPL[i];
        end else begin
          regs_r[i] <= reg_nxt[i] & REG_IMPL[i];
        end
      end
    end
  endgenerate

  assign wake_flags = rst_req.wake_core_flags | rst_req.wake_periph_flags;

  // Condition-dependent bits on top of the table values
  always_comb begin
    reg_nxt = base_nxt;
    if (load) begin
      case (cls)
        CL_POR: begin
          reg_nxt[SLOT_PWR][POWERON_BIT] = 1'b0;
          reg_nxt[SLOT_INTCTL][GIE_BIT] = 1'b0;
        end
        CL_OTHER: begin
          reg_nxt[SLOT_INTCTL][GIE_BIT] = 1'b0;
          case (rst_req.kind)
            RK_EXT_PIN: begin
              if (rst_req.in_sleep) begin
                reg_nxt[SLOT_CORE_FLAGS][TIMEOUT_BIT] = 1'b1;
                reg_nxt[SLOT_CORE_FLAGS][POWERDOWN_BIT] = 1'b0;
              end
            end
            RK_WATCHDOG: begin
              reg_nxt[SLOT_CORE_FLAGS][TIMEOUT_BIT] = 1'b0;
            end
            RK_BROWNOUT: begin
              reg_nxt[SLOT_CORE_FLAGS][TIMEOUT_BIT] = 1'b1;
              reg_nxt[SLOT_CORE_FLAGS][POWERDOWN_BIT] = 1'b1;
              reg_nxt[SLOT_PWR][SW_BOR_EN_BIT] = 1'b1;
              reg_nxt[SLOT_PWR][BROWNOUT_BIT] = 1'b0;
            end
            default: begin
              reg_nxt[SLOT_PWR][BROWNOUT_BIT] = regs_r[SLOT_PWR][BROWNOUT_BIT];
            end
          endcase
        end
        CL_WAKE: begin
          if (rst_req.kind == RK_WAKE_IRQ && regs_r[SLOT_INTCTL][GIE_BIT]) begin
            reg_nxt[SLOT_PCL] = IRQ_VECTOR_LOW;
          end else begin
            reg_nxt[SLOT_PCL] = regs_r[SLOT_PCL] + 8'h01;
          end
          reg_nxt[SLOT_CORE_FLAGS][TIMEOUT_BIT] = (rst_req.kind == RK_WAKE_IRQ);
          reg_nxt[SLOT_CORE_FLAGS][POWERDOWN_BIT] = 1'b0;
          reg_nxt[SLOT_INTCTL] = regs_r[SLOT_INTCTL] | rst_req.wake_core_flags;
          reg_nxt[SLOT_PIRQ] = regs_r[SLOT_PIRQ] | rst_req.wake_periph_flags;
          // A wake with no source reported still leaves a flag behind
          if (wake_flags == 8'h00) begin
            reg_nxt[SLOT_INTCTL][WAKE_FALLBACK_BIT] = 1'b1;
          end
        end
        default: begin
          reg_nxt = base_nxt;
        end
      endcase
    end
  end

  // Read mux; analog-selected port pins read low whatever the latch holds
  always_comb begin
    rd_data = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      if (hit[k]) begin
        rd_data = rd_data | (regs_r[k] & REG_IMPL[k]);
      end
    end
    if (hit[SLOT_PORT_A]) begin
      rd_data = rd_data & ~{2'b00, port_a_analog};
    end
    if (hit[SLOT_PORT_C]) begin
      rd_data = rd_data & ~{2'b00, port_c_analog};
    end
    if (hit_stat) begin
      rd_data = {{(8-NEV){1'b0}}, stat_r};
    end
    if (hit_mask) begin
      rd_data = {{(8-NEV){1'b0}}, mask_r};
    end
  end

  // APB: one wait state, read data captured on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        prdata <= {24'h00_0000, rd_data};
        pslverr <= !mapped;
      end
    end
  end

  // Events of each load; a set in the clearing cycle wins
  always_comb begin
    ev_set = '0;
    if (load) begin
      ev_set[EV_POR] = (cls == CL_POR);
      ev_set[EV_OTHER] = (cls == CL_OTHER);
      ev_set[EV_BROWNOUT] = (cls == CL_OTHER) && (rst_req.kind == RK_BROWNOUT);
      ev_set[EV_WAKE] = (cls == CL_WAKE);
    end
    stat_nxt = stat_r;
    // Clear only what the read returned; an event landing between capture
    // and completion would otherwise vanish unseen
    if (rd_done && hit_stat) begin
      stat_nxt = stat_r & ~stat_seen_r;
    end
    stat_nxt = stat_nxt | ev_set;
    mask_nxt = mask_r;
    if (wr_en && hit_mask) begin
      mask_nxt = pwdata[NEV-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      stat_seen_r <= '0;
      mask_r <= EV_MASK_RST;
      irq <= 1'b0;
      load_done <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (acc && !pready && hit_stat) begin
        stat_seen_r <= stat_r;
      end
      mask_r <= mask_nxt;
      irq <= |(stat_nxt & mask_nxt);
      load_done <= load;
    end
  end

  // Mirrors kept in flops so the outputs leave straight from registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
      program_counter_low <= 8'h00;
    end else begin
      global_irq_enable <= reg_nxt[SLOT_INTCTL][GIE_BIT];
      program_counter_low <= reg_nxt[SLOT_PCL];
    end
  end
endmodule

// ===== rtl/reset_init_pkg.sv
// Package: register map, reset value tables and reset request types
package reset_init_pkg;
  localparam int NREG = 32;
  localparam int AW = 12;
  typedef logic [7:0] byte_t;

  // Register index per slot; byte address is four times the index
  localparam byte_t REG_OFF [NREG] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0a,
    8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1e,
    8'h1f, 8'h81, 8'h85, 8'h87, 8'h8c, 8'h8e, 8'h8f, 8'h20};
  // Implemented bits; all others read zero
  localparam byte_t REG_IMPL [NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h1f,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h03, 8'hff,
    8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h33, 8'h7f, 8'hff};
  // Power-on values and the bits they define (others keep contents)
  localparam byte_t REG_POR_VAL [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 8'h00,
    8'h00, 8'hff, 8'h3f, 8'h3f, 8'h00, 8'h10, 8'h60, 8'h00};
  localparam byte_t REG_POR_DEF [NREG] = '{
    8'h00, 8'h00, 8'hff, 8'hf8, 8'h00, 8'h17, 8'h0f, 8'h1f,
    8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h7f, 8'h00,
    8'h00, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h03, 8'h00,
    8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h32, 8'h77, 8'h00};
  // Values for the other resets and the bits they define
  localparam byte_t REG_OTH_VAL [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 8'h00,
    8'h00, 8'hff, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h60, 8'h00};
  localparam byte_t REG_OTH_DEF [NREG] = '{
    8'h00, 8'h00, 8'hff, 8'he0, 8'h00, 8'h17, 8'h0f, 8'h1f,
    8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h7f, 8'h00,
    8'h00, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h03, 8'h00,
    8'hdf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h20, 8'h77, 8'h00};

  // Slots that get special handling
  localparam int SLOT_PCL = 2;
  localparam int SLOT_CORE_FLAGS = 3;
  localparam int SLOT_PORT_A = 5;
  localparam int SLOT_PORT_C = 6;
  localparam int SLOT_INTCTL = 8;
  localparam int SLOT_PIRQ = 9;
  localparam int SLOT_CONV_RES = 23;
  localparam int SLOT_PWR = 29;

  // Bit positions
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;
  localparam int BROWNOUT_BIT = 0;
  localparam int POWERON_BIT = 1;
  localparam int SW_BOR_EN_BIT = 4;
  localparam int GIE_BIT = 7;
  localparam int WAKE_FALLBACK_BIT = 0;
  localparam byte_t IRQ_VECTOR_LOW = 8'h04;
  localparam byte_t CORE_FLAGS_WR = 8'he7;

  // Event status and mask registers
  localparam byte_t EV_STAT_IDX = 8'hc0;
  localparam byte_t EV_MASK_IDX = 8'hc1;
  localparam int NEV = 4;
  localparam int EV_POR = 0;
  localparam int EV_OTHER = 1;
  localparam int EV_BROWNOUT = 2;
  localparam int EV_WAKE = 3;
  localparam logic [NEV-1:0] EV_MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    RK_POR, RK_EXT_PIN, RK_WATCHDOG, RK_BROWNOUT, RK_WAKE_IRQ, RK_WAKE_WATCHDOG
  } reset_kind_t;
  typedef enum logic [1:0] {CL_POR, CL_OTHER, CL_WAKE} reset_class_t;

  typedef struct packed {
    logic valid;
    reset_kind_t kind;
    logic in_sleep;
    logic supply_low;
    byte_t wake_core_flags;
    byte_t wake_periph_flags;
  } reset_req_t;
endpackage

// ===== dv/reset_register_initializer_chk.sv
// Checker for the reset loader's bus timing, load pulse and mirrors
`timescale 1ns/1ps
module reset_register_initializer_chk
  import reset_init_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire reset_req_t rst_req,
  input wire logic irq,
  input wire logic load_done,
  input wire logic global_irq_enable,
  input wire logic [7:0] program_counter_low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence seq_setup;
    psel && !penable;
  endsequence
  sequence seq_answer;
    !pready ##1 pready;
  endsequence
  wire logic hard_kind = rst_req.valid && !(rst_req.kind inside {RK_WAKE_IRQ, RK_WAKE_WATCHDOG});
  AST_ONE_WAIT: assert property (seq_setup |=> seq_answer) else $error("wait state count wrong");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_LOAD_DONE: assert property (rst_req.valid |=> load_done) else $error("load pulse missing");
  AST_LOAD_ONLY: assert property (!rst_req.valid |=> !load_done) else $error("stray load pulse");
  AST_GIE_CLEAR: assert property (hard_kind |=> !global_irq_enable) else $error("enable kept");
  AST_PC_ZERO: assert property (hard_kind |=> program_counter_low == 8'h00) else $error("pc not zero");
  AST_VECTOR: assert property (rst_req.valid && rst_req.kind == RK_WAKE_IRQ && global_irq_enable
    |=> program_counter_low == IRQ_VECTOR_LOW) else $error("vector not loaded");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> load_done || $past(pready && pwrite))
    else $error("irq without cause");
endmodule
bind reset_register_initializer reset_register_initializer_chk chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .prdata, .pready, .rst_req, .irq, .load_done, .global_irq_enable,
  .program_counter_low);

// ===== dv/tb.sv
// Testbench for the reset loader: reset classes, flags, masking and events
`timescale 1ns/1ps
module tb;
  import reset_init_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, load_done, global_irq_enable;
  logic [7:0] program_counter_low;
  logic [5:0] port_a_analog = 6'h00, port_c_analog = 6'h00;
  reset_req_t rst_req = '0;
  int fails = 0, checks_done = 0;
  reset_register_initializer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rst_req, .port_a_analog, .port_c_analog, .irq,
    .load_done, .global_irq_enable, .program_counter_low);
  always #12.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits on pready with a bound; sampling right at the edge sees pre-edge values
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic pulse(input reset_kind_t k, input logic sleep, input logic low);
    repeat (2) @(posedge pclk);
    rst_req <= '{1'b1, k, sleep, low, 8'h00, 8'h00};
    @(posedge pclk);
    rst_req.valid <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_power_on;
    apb(0, 12'h238, 0); chk(r, 32'h10);
    apb(1, 12'h028, 8'hff); apb(0, 12'h028, 0); chk(r, 32'h1f);
    apb(0, 12'h0fc, 0); chk({err, r[30:0]}, 32'h80000000);
  endtask
  task automatic t_brownout;
    apb(1, 12'h304, 8'h04); apb(1, 12'h238, 8'h03);
    pulse(RK_BROWNOUT, 0, 0); chk(irq, 1);
    apb(0, 12'h238, 0); chk(r, 32'h12);
    apb(0, 12'h300, 0); chk(r & 32'h4, 32'h4);
    @(posedge pclk); chk(irq, 0);
  endtask
  task automatic t_other;
    apb(1, 12'h238, 8'h03); pulse(RK_EXT_PIN, 1, 0);
    apb(0, 12'h238, 0); chk(r & 32'h3, 32'h3);
    pulse(RK_WATCHDOG, 0, 1); apb(0, 12'h238, 0); chk(r & 32'h3, 32'h1);
  endtask
  task automatic t_wake;
    apb(1, 12'h02c, 8'h80); pulse(RK_WAKE_IRQ, 1, 0);
    apb(0, 12'h008, 0); chk(r, 32'h04);
    apb(0, 12'h02c, 0); chk(r, 32'h81);
    pulse(RK_WAKE_WATCHDOG, 1, 0); apb(0, 12'h008, 0); chk(r, 32'h05);
    pulse(RK_POR, 0, 0); chk(global_irq_enable, 0);
  endtask
  task automatic t_analog;
    apb(1, 12'h014, 8'h3f); apb(1, 12'h01c, 8'h3f);
    port_a_analog <= 6'h3f; port_c_analog <= 6'h0f;
    apb(0, 12'h014, 0); chk(r, 32'h00);
    apb(0, 12'h01c, 0); chk(r, 32'h30);
    port_a_analog <= 6'h00; apb(0, 12'h014, 0); chk(r, 32'h3f);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_power_on;
    t_brownout;
    t_other;
    t_wake;
    t_analog;
    stop_test;
  end
  // A hang in a handshake ends the run here
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    stop_test;
  end
endmodule
